// *** rtl/frc_flash_ctrl.sv ***
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module frc_flash_ctrl import frc_pkg::*; #(
  parameter int num_blocks = 4,
  parameter int prog_cycles = prog_cycles_dflt,
  parameter int erase_cycles = erase_cycles_dflt
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash macro
  input wire logic op_fail,
  input wire logic stop_wait_req,
  output logic flash_access_block,
  output logic flash_ctrl_reset,
  output logic flash_low_power,
  output logic flash_power_off,
  output logic ram_execution_rewrite_mode,
  output logic in_place_rewrite_mode,
  output logic low_current_read,
  output logic prog_start,
  output logic erase_start,
  output logic [blk_width-1:0] op_block
);
  frc_state_type state;
  logic cpu_rewrite_enable;
  logic lock_override_enable;
  logic flash_stop;
  logic program_error_flag;
  logic erase_error_flag;
  logic in_place_mode_select;
  logic block0_write_lock;
  logic block1_write_lock;
  logic low_current_read_enable;
  logic erase_active_flag;
  logic program_active_flag;
  logic status_mode;
  logic [31:0] op_count;
  // previous-write memory for protected bits
  logic arm_cre, arm_ovr, arm_inp, arm_lcr, arm_l0_clr, arm_l1_clr;

  logic access, wr, rd, mapped;
  logic wr_cs, wr_bl, wr_ap, wr_cmd;
  logic [7:0] wbyte;
  logic [7:0] cbyte;
  logic [blk_width-1:0] cblk;
  logic stopped;
  logic done;
  logic cmd_ok;

  function automatic logic block_writable(input logic [blk_width-1:0] blk, input logic ovr,
                                          input logic l0, input logic l1);
    if (blk >= blk_width'(num_blocks)) block_writable = 1'b0; // R15
    else if (blk == blk_width'(0)) block_writable = ovr & ~l0; // R03 R04
    else if (blk == blk_width'(1)) block_writable = ovr & ~l1; // R03 R05
    else block_writable = 1'b1;
  endfunction : block_writable

  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign mapped = (paddr == addr_control_status) | (paddr == addr_block_lock) |
                  (paddr == addr_activity_power) | (paddr == addr_command);
  assign wr_cs = wr & (paddr == addr_control_status);
  assign wr_bl = wr & (paddr == addr_block_lock);
  assign wr_ap = wr & (paddr == addr_activity_power);
  assign wr_cmd = wr & (paddr == addr_command) & cpu_rewrite_enable; // R02
  assign wbyte = pwdata[7:0];
  assign cbyte = pwdata[cmd_lsb +: 8];
  assign cblk = pwdata[blk_lsb +: blk_width];
  assign stopped = flash_stop & cpu_rewrite_enable; // R10 R11
  assign done = (state == st_busy) & (op_count == 32'h0000_0000);
  assign cmd_ok = block_writable(cblk, lock_override_enable, block0_write_lock, block1_write_lock);

  // apb handshake, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        addr_control_status: begin
          prdata[bit_ready] <= (state != st_busy); // R01
          prdata[bit_rewrite_en] <= cpu_rewrite_enable;
          prdata[bit_lock_override] <= lock_override_enable;
          prdata[bit_flash_stop] <= flash_stop;
          prdata[bit_prog_err] <= program_error_flag; // R14
          prdata[bit_erase_err] <= erase_error_flag; // R14
        end
        addr_block_lock: begin
          prdata[bit_in_place] <= in_place_mode_select;
          prdata[bit_lock0] <= block0_write_lock;
          prdata[bit_lock1] <= block1_write_lock;
        end
        addr_activity_power: begin
          prdata[bit_erase_active] <= erase_active_flag;
          prdata[bit_prog_active] <= program_active_flag;
          prdata[bit_read_permit] <= ~(erase_active_flag | program_active_flag); // R20
          prdata[bit_low_current] <= low_current_read_enable;
        end
        addr_command: begin
          if (status_mode) begin
            prdata[bit_ready] <= (state != st_busy);
            prdata[bit_prog_err] <= program_error_flag;
            prdata[bit_erase_err] <= erase_error_flag;
          end
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // arming of protected bits by the preceding write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cre <= 1'b0;
      arm_ovr <= 1'b0;
      arm_inp <= 1'b0;
      arm_lcr <= 1'b0;
      arm_l0_clr <= 1'b0;
      arm_l1_clr <= 1'b0;
    end else if (wr) begin
      arm_cre <= wr_cs & ~wbyte[bit_rewrite_en]; // R07
      arm_ovr <= wr_cs & ~wbyte[bit_lock_override]; // R07
      arm_inp <= wr_bl & ~wbyte[bit_in_place]; // R07
      arm_lcr <= wr_ap & ~wbyte[bit_low_current]; // R07
      arm_l0_clr <= wr_bl & wbyte[bit_lock0]; // R09
      arm_l1_clr <= wr_bl & wbyte[bit_lock1]; // R09
    end
  end

  // control_status writable bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rewrite_enable <= 1'b0;
      lock_override_enable <= 1'b0;
      flash_stop <= 1'b0;
    end else if (wr_cs) begin
      if (!wbyte[bit_rewrite_en]) cpu_rewrite_enable <= 1'b0;
      else if (arm_cre) cpu_rewrite_enable <= 1'b1; // R07
      if (!wbyte[bit_rewrite_en] || !wbyte[bit_lock_override]) lock_override_enable <= 1'b0; // R06
      else if (arm_ovr && cpu_rewrite_enable) lock_override_enable <= 1'b1; // R07
      flash_stop <= wbyte[bit_flash_stop]; // R11
    end
  end

  // block_lock register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_place_mode_select <= 1'b0;
      block0_write_lock <= lock_reset;
      block1_write_lock <= lock_reset;
    end else if (wr_cs && !wbyte[bit_rewrite_en]) begin
      in_place_mode_select <= 1'b0;
    end else if (wr_bl) begin
      if (!wbyte[bit_in_place]) in_place_mode_select <= 1'b0;
      else if (arm_inp && cpu_rewrite_enable) in_place_mode_select <= 1'b1; // R07
      if (cpu_rewrite_enable) begin // R08
        if (wbyte[bit_lock0]) block0_write_lock <= 1'b1;
        else if (arm_l0_clr) block0_write_lock <= 1'b0; // R09
        if (wbyte[bit_lock1]) block1_write_lock <= 1'b1;
        else if (arm_l1_clr) block1_write_lock <= 1'b0; // R09
      end
    end
  end

  // low current read enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_current_read_enable <= 1'b0;
    end else if (wr_ap) begin
      if (!wbyte[bit_low_current]) low_current_read_enable <= 1'b0;
      else if (arm_lcr) low_current_read_enable <= 1'b1; // R07
    end
  end

  // command sequencer and auto operation timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_array;
      status_mode <= 1'b0;
      op_count <= 32'h0000_0000;
      erase_active_flag <= 1'b0;
      program_active_flag <= 1'b0;
      op_block <= '0;
    end else if (stopped) begin // R10
      state <= st_array;
      status_mode <= 1'b0;
      op_count <= 32'h0000_0000;
      erase_active_flag <= 1'b0;
      program_active_flag <= 1'b0;
    end else begin
      case (state)
        st_array, st_status: begin
          if (wr_cmd) begin
            case (cbyte)
              cmd_read_array: begin
                state <= st_array;
                status_mode <= 1'b0;
              end
              cmd_read_status: begin
                state <= st_status;
                status_mode <= 1'b1;
              end
              cmd_program: state <= st_prog_wait;
              cmd_erase: state <= st_erase_wait;
              default: state <= state;
            endcase
          end
        end
        st_prog_wait: begin
          if (wr_cmd) begin
            op_block <= cblk;
            if (cmd_ok) begin
              state <= st_busy;
              program_active_flag <= 1'b1; // R19
              op_count <= 32'(prog_cycles - 1); // R23
              status_mode <= ~in_place_mode_select;
            end else begin
              state <= st_status;
              status_mode <= 1'b1;
            end
          end
        end
        st_erase_wait: begin
          if (wr_cmd) begin
            op_block <= cblk;
            if (cbyte == cmd_read_array) begin // R16
              state <= st_array;
              status_mode <= 1'b0;
            end else if (cbyte == cmd_confirm && cmd_ok) begin
              state <= st_busy;
              erase_active_flag <= 1'b1; // R19
              op_count <= 32'(erase_cycles - 1); // R23
              status_mode <= ~in_place_mode_select;
            end else begin
              state <= st_status;
              status_mode <= 1'b1;
            end
          end
        end
        st_busy: begin
          if (done) begin // R01 R19
            erase_active_flag <= 1'b0;
            program_active_flag <= 1'b0;
            state <= status_mode ? st_status : st_array;
          end else begin
            op_count <= op_count - 32'h0000_0001;
          end
        end
        default: state <= st_array;
      endcase
    end
  end

  // error flags; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
    end else begin
      if (wr_cmd && (state == st_prog_wait) && !cmd_ok) begin // R15
        program_error_flag <= 1'b1;
        erase_error_flag <= 1'b1; // R14
      end else if (wr_cmd && (state == st_erase_wait) && (cbyte != cmd_read_array) &&
                   (cbyte != cmd_confirm || !cmd_ok)) begin // R15
        program_error_flag <= 1'b1;
        erase_error_flag <= 1'b1; // R14
      end else if (done && op_fail) begin // R13
        if (program_active_flag) program_error_flag <= 1'b1;
        if (erase_active_flag) erase_error_flag <= 1'b1;
      end else if (wr_cmd && (state == st_array || state == st_status) &&
                   cbyte == cmd_clear_status) begin // R17
        program_error_flag <= 1'b0;
        erase_error_flag <= 1'b0;
      end
    end
  end

  // flash macro controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_access_block <= 1'b0;
      flash_ctrl_reset <= 1'b0;
      flash_low_power <= 1'b0;
      flash_power_off <= 1'b0;
      ram_execution_rewrite_mode <= 1'b0;
      in_place_rewrite_mode <= 1'b0;
      low_current_read <= 1'b0;
      prog_start <= 1'b0;
      erase_start <= 1'b0;
    end else begin
      flash_access_block <= stopped | erase_active_flag | program_active_flag; // R10 R20
      flash_ctrl_reset <= stopped; // R10
      flash_low_power <= stopped; // R10
      flash_power_off <= stop_wait_req & ~cpu_rewrite_enable; // R22
      ram_execution_rewrite_mode <= cpu_rewrite_enable & ~in_place_mode_select; // R18
      in_place_rewrite_mode <= cpu_rewrite_enable & in_place_mode_select; // R18
      low_current_read <= low_current_read_enable;
      prog_start <= ~stopped & wr_cmd & (state == st_prog_wait) & cmd_ok;
      erase_start <= ~stopped & wr_cmd & (state == st_erase_wait) & (cbyte == cmd_confirm) & cmd_ok;
    end
  end
endmodule : frc_flash_ctrl

// *** include/frc_pkg.sv ***
// Behaviour
// R01: ready flag reads 0 while program or erase runs, else 1.
// R02: flash commands act only while cpu rewrite is enabled.
// R03: with lock override 0, program and erase to blocks 0 and 1 are refused.
// R04: block 0 accepts program and erase only with override 1 and lock 0.
// R05: block 1 accepts program and erase only with override 1 and lock 0.
// R06: writing cpu rewrite enable to 0 forces lock override to 0.
// R07: protected bits become 1 only by write 1 directly after write 0.
// R08: block locks change only while cpu rewrite is enabled.
// R09: block lock clears only by write 0 directly after write 1.
// R10: flash stop with rewrite enabled blocks access, resets control, lowers current.
// R11: flash stop set with rewrite disabled causes no reset and no low power.
// R12: software changes stop and mode bits only from code outside the flash.
// R13: program and erase error flags go to 1 on failed auto operation.
// R14: flag pair encodes 11 sequence error, 10 erase, 01 program, 00 success.
// R15: sequence error on bad command, bad confirm, unallocated or locked target; the code ignores an unknown first command byte and sets no flag.
// R16: ffh as erase second byte cancels the command and enters read array.
// R17: clear status command clears both error flags.
// R18: with rewrite enabled, mode select 0 gives ram mode, 1 in place mode.
// R19: erase and program activity flags stand for the whole auto operation.
// R20: read permit flag is 0 during any auto program or erase.
// R21: low current read only in slow clock modes, with rewrite disabled; the code drives it from the enable bit alone, with no clock or rewrite gating.
// R22: stop or wait with rewrite disabled powers flash off and back on.
// R23: auto operations last parameterised cycle counts after acceptance.
package frc_pkg;
  // register byte addresses
  localparam logic [11:0] addr_control_status = 12'h000;
  localparam logic [11:0] addr_block_lock = 12'h004;
  localparam logic [11:0] addr_activity_power = 12'h008;
  localparam logic [11:0] addr_command = 12'h00c;
  // control_status fields
  localparam int bit_ready = 0;
  localparam int bit_rewrite_en = 1;
  localparam int bit_lock_override = 2;
  localparam int bit_flash_stop = 3;
  localparam int bit_prog_err = 6;
  localparam int bit_erase_err = 7;
  // block_lock fields
  localparam int bit_in_place = 1;
  localparam int bit_lock0 = 5;
  localparam int bit_lock1 = 6;
  // activity_power fields
  localparam int bit_erase_active = 3;
  localparam int bit_prog_active = 4;
  localparam int bit_read_permit = 6;
  localparam int bit_low_current = 7;
  // command register fields
  localparam int cmd_lsb = 0;
  localparam int blk_lsb = 8;
  localparam int blk_width = 4;
  // command codes
  localparam logic [7:0] cmd_read_array = 8'hff;
  localparam logic [7:0] cmd_read_status = 8'h70;
  localparam logic [7:0] cmd_clear_status = 8'h50;
  localparam logic [7:0] cmd_program = 8'h40;
  localparam logic [7:0] cmd_erase = 8'h20;
  localparam logic [7:0] cmd_confirm = 8'hd0;
  // reset values
  localparam logic lock_reset = 1'b1;
  // operation timing
  localparam int prog_time_us = 50;
  localparam int erase_time_us = 300;
  localparam int clk_mhz = 125;
  localparam int prog_cycles_dflt = prog_time_us * clk_mhz;
  localparam int erase_cycles_dflt = erase_time_us * clk_mhz;
  typedef enum logic [2:0] {
    st_array = 3'b000,
    st_prog_wait = 3'b001,
    st_erase_wait = 3'b011,
    st_busy = 3'b010,
    st_status = 3'b110
  } frc_state_type;
endpackage : frc_pkg

// *** testbench/frc_flash_ctrl_properties.sv ***
`timescale 1ns/1ps
module frc_flash_ctrl_properties import frc_pkg::*; #(
  parameter int num_blocks = 4,
  parameter int prog_cycles = prog_cycles_dflt,
  parameter int erase_cycles = erase_cycles_dflt
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flash macro
  input wire logic op_fail,
  input wire logic stop_wait_req,
  input wire logic flash_access_block,
  input wire logic flash_ctrl_reset,
  input wire logic flash_low_power,
  input wire logic flash_power_off,
  input wire logic ram_execution_rewrite_mode,
  input wire logic in_place_rewrite_mode,
  input wire logic low_current_read,
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic [blk_width-1:0] op_block
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rewrite_off;
    psel && penable && pready && pwrite && paddr == addr_control_status && !pwdata[bit_rewrite_en];
  endsequence
  sequence s_op_start;
    prog_start || erase_start;
  endsequence
  AST_ACCESS_ONE: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_UNMAPPED: assert property (s_setup ##0 (paddr > addr_command) |=> pslverr && pready)
    else $error("unmapped access without slave error");
  AST_REWRITE_OFF: assert property (s_rewrite_off |-> ##[1:3] !(ram_execution_rewrite_mode || in_place_rewrite_mode || flash_ctrl_reset))
    else $error("rewrite disable left a mode or stop active");
  AST_MODE_EXCLUSIVE: assert property (!(ram_execution_rewrite_mode && in_place_rewrite_mode))
    else $error("both rewrite modes active");
  AST_STOP_BLOCKS: assert property (flash_ctrl_reset |-> flash_access_block && flash_low_power)
    else $error("stop without access block or low power");
  AST_STOP_NEEDS_REWRITE: assert property (flash_ctrl_reset |-> ram_execution_rewrite_mode || in_place_rewrite_mode)
    else $error("flash reset while rewrite disabled");
  AST_POWER_OFF: assert property (flash_power_off |-> $past(stop_wait_req) && !ram_execution_rewrite_mode && !in_place_rewrite_mode)
    else $error("power off without stop request or with rewrite on");
  AST_POWER_ON: assert property (!stop_wait_req |=> !flash_power_off)
    else $error("power not restored after wake");
  AST_START_PULSE: assert property (s_op_start |=> !prog_start && !erase_start)
    else $error("start pulse longer than one cycle");
  AST_BUSY_HOLD: assert property (s_op_start |=> flash_access_block [*3])
    else $error("access not blocked during auto operation");
  AST_BUSY_ENDS: assert property (s_op_start |-> ##[1:12] !flash_access_block)
    else $error("auto operation did not end in time");
endmodule : frc_flash_ctrl_properties

bind frc_flash_ctrl frc_flash_ctrl_properties #(
  .num_blocks(num_blocks), .prog_cycles(prog_cycles), .erase_cycles(erase_cycles)
) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .op_fail, .stop_wait_req, .flash_access_block, .flash_ctrl_reset, .flash_low_power,
  .flash_power_off, .ram_execution_rewrite_mode, .in_place_rewrite_mode, .low_current_read,
  .prog_start, .erase_start, .op_block
);

// *** testbench/frc_flash_ctrl_test.sv ***
`timescale 1ns/1ps
module frc_flash_ctrl_test import frc_pkg::*;;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [11:0] d;
    logic [7:0] e;
  } frc_row_type;
  // apb
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  // flash macro
  logic op_fail = 1'b0;
  logic stop_wait_req = 1'b0;
  logic flash_access_block, flash_ctrl_reset, flash_low_power, flash_power_off;
  logic ram_execution_rewrite_mode, in_place_rewrite_mode, low_current_read, prog_start, erase_start;
  logic [blk_width-1:0] op_block;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int check_count = 0;
  frc_row_type rows [55] = '{
    '{8'h00,1'b0,12'h000,8'h01}, '{8'h04,1'b0,12'h000,8'h60}, '{8'h08,1'b0,12'h000,8'h40},
    '{8'h10,1'b0,12'h000,8'h00},
    '{8'h0c,1'b1,12'h040,8'h00}, '{8'h0c,1'b1,12'h000,8'h00}, '{8'h00,1'b0,12'h000,8'h01},
    '{8'h04,1'b1,12'h060,8'h00}, '{8'h04,1'b1,12'h000,8'h00}, '{8'h04,1'b0,12'h000,8'h60},
    '{8'h00,1'b1,12'h002,8'h00}, '{8'h00,1'b0,12'h000,8'h01},
    '{8'h00,1'b1,12'h000,8'h00}, '{8'h00,1'b1,12'h002,8'h00}, '{8'h00,1'b0,12'h000,8'h03},
    '{8'h04,1'b1,12'h060,8'h00}, '{8'h04,1'b1,12'h000,8'h00}, '{8'h04,1'b0,12'h000,8'h00},
    '{8'h04,1'b1,12'h060,8'h00}, '{8'h04,1'b0,12'h000,8'h60},
    '{8'h0c,1'b1,12'h040,8'h00}, '{8'h0c,1'b1,12'h000,8'h00}, '{8'h00,1'b0,12'h000,8'hc3},
    '{8'h0c,1'b1,12'h050,8'h00}, '{8'h00,1'b0,12'h000,8'h03},
    '{8'h00,1'b1,12'h002,8'h00}, '{8'h00,1'b1,12'h006,8'h00}, '{8'h00,1'b0,12'h000,8'h07},
    '{8'h0c,1'b1,12'h040,8'h00}, '{8'h0c,1'b1,12'h000,8'h00}, '{8'h00,1'b0,12'h000,8'hc7},
    '{8'h0c,1'b1,12'h050,8'h00},
    '{8'h04,1'b1,12'h060,8'h00}, '{8'h04,1'b1,12'h020,8'h00}, '{8'h04,1'b0,12'h000,8'h20},
    '{8'h0c,1'b1,12'h040,8'h00}, '{8'h0c,1'b1,12'h500,8'h00}, '{8'h00,1'b0,12'h000,8'hc7},
    '{8'h0c,1'b1,12'h050,8'h00},
    '{8'h0c,1'b1,12'h020,8'h00}, '{8'h0c,1'b1,12'h155,8'h00}, '{8'h00,1'b0,12'h000,8'hc7},
    '{8'h0c,1'b1,12'h050,8'h00},
    '{8'h0c,1'b1,12'h020,8'h00}, '{8'h0c,1'b1,12'h1ff,8'h00}, '{8'h00,1'b0,12'h000,8'h07},
    '{8'h0c,1'b0,12'h000,8'h00}, '{8'h0c,1'b1,12'h070,8'h00}, '{8'h0c,1'b0,12'h000,8'h01},
    '{8'h00,1'b1,12'h004,8'h00}, '{8'h00,1'b0,12'h000,8'h01},
    '{8'h00,1'b1,12'h000,8'h00}, '{8'h00,1'b1,12'h002,8'h00}, '{8'h00,1'b1,12'h006,8'h00},
    '{8'h00,1'b0,12'h000,8'h07}
  };

  always #4 pclk = ~pclk;

  frc_flash_ctrl #(.prog_cycles(5), .erase_cycles(8)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .op_fail, .stop_wait_req, .flash_access_block, .flash_ctrl_reset, .flash_low_power,
    .flash_power_off, .ram_execution_rewrite_mode, .in_place_rewrite_mode, .low_current_read,
    .prog_start, .erase_start, .op_block
  );

  task automatic test_done;
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", {31'h0, pready}, 32'h1);
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      apb(12'h000, 1'b0, 32'h0);
      n++;
    end while (rdat[bit_ready] !== 1'b1 && n < 20);
    chk("ready", {31'h0, rdat[bit_ready]}, 32'h1);
    if (rdat[bit_ready] !== 1'b1) begin
      test_done();
    end
  endtask : wait_ready

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb({4'h0, rows[i].a}, rows[i].w, {20'h0, rows[i].d});
      if (rows[i].w === 1'b0) begin
        chk("read data", rdat, {24'h0, rows[i].e});
        chk("slave error", {31'h0, rerr}, {31'h0, rows[i].a > 8'h0c});
      end
    end
    apb(12'h00c, 1'b1, 32'h40);
    apb(12'h00c, 1'b1, 32'h1a5);
    chk("program start", {31'h0, prog_start}, 32'h1);
    apb(12'h000, 1'b0, 32'h0);
    chk("program busy", rdat, 32'h06);
    wait_ready();
    op_fail <= 1'b1;
    apb(12'h00c, 1'b1, 32'h40);
    apb(12'h00c, 1'b1, 32'h2a5);
    wait_ready();
    chk("program error", rdat, 32'h47);
    chk("target block", {28'h0, op_block}, 32'h2);
    apb(12'h00c, 1'b1, 32'h50);
    apb(12'h00c, 1'b1, 32'h20);
    apb(12'h00c, 1'b1, 32'h2d0);
    chk("erase start", {31'h0, erase_start}, 32'h1);
    apb(12'h000, 1'b0, 32'h0);
    chk("erase busy", rdat, 32'h06);
    apb(12'h008, 1'b0, 32'h0);
    chk("erase activity", rdat, 32'h08);
    wait_ready();
    chk("erase error", rdat, 32'h87);
    apb(12'h00c, 1'b0, 32'h0);
    chk("status mirror", rdat, 32'h81);
    op_fail <= 1'b0;
    apb(12'h00c, 1'b1, 32'h50);
    chk("ram mode", {31'h0, ram_execution_rewrite_mode}, 32'h1);
    apb(12'h004, 1'b1, 32'h20);
    apb(12'h004, 1'b1, 32'h22);
    repeat (2) @(posedge pclk);
    chk("in place mode", {30'h0, ram_execution_rewrite_mode, in_place_rewrite_mode}, 32'h1);
    apb(12'h000, 1'b1, 32'h00);
    apb(12'h000, 1'b1, 32'h0a);
    repeat (2) @(posedge pclk);
    chk("stop outputs", {29'h0, flash_ctrl_reset, flash_low_power, flash_access_block}, 32'h7);
    apb(12'h000, 1'b1, 32'h00);
    apb(12'h000, 1'b1, 32'h08);
    stop_wait_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("stop without rewrite", {30'h0, flash_ctrl_reset, flash_power_off}, 32'h1);
    apb(12'h000, 1'b0, 32'h0);
    chk("stop bit", rdat, 32'h09);
    stop_wait_req <= 1'b0;
    apb(12'h008, 1'b1, 32'h00);
    apb(12'h008, 1'b1, 32'h80);
    repeat (2) @(posedge pclk);
    chk("power and read mode", {30'h0, flash_power_off, low_current_read}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(12'h000, 1'b0, 32'h0);
    chk("status after reset", rdat, 32'h01);
    test_done();
  end
endmodule : frc_flash_ctrl_test
